// ==== rtl/rac_bank.sv ====
`timescale 1ns/1ps
// ************************************************************
// Attribute cell bank
// ************************************************************
// Notes on behaviour
// R1 - Strap-loaded bits freeze until next reset
// R2 - Read returns value then clears; writes ignored
// R3 - Read clears; writes also update value
// R4 - Accessor masks and preserves reserved bits
// R5 - Read-only bits ignore writes
// R6 - Read-write bits store written value
// R7 - Writing zero keeps, writing one clears
// R8 - Only hardware sets; only software clears
// R9 - Locked bits accept writes only when unlocked
// R10 - Locked bits survive hot, not fundamental reset
// R11 - Sticky read-only untouched by hot reset
// R12 - Aux power keeps marked sticky bits
// R13 - Sticky read-write untouched by hot reset
// R14 - Sticky one-clear bits survive hot reset
// R15 - Transient field reads zero, gates write
// R16 - Zero bits read zero, written zero
// R17 - Loader writes behave like root writes
// R18 - Set event beats same-cycle clear
module rac_bank #(
  parameter rac_pkg::rac_layout_type BIT_ATTR = rac_pkg::RAC_DEFAULT_LAYOUT,
  parameter logic [rac_pkg::RAC_WIDTH-1:0] DEFAULT_VALUE = rac_pkg::RAC_DEFAULT_VALUE,
  parameter logic [rac_pkg::RAC_WIDTH-1:0] FR_STICKY_MASK = rac_pkg::RAC_DEFAULT_FR_STICKY
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // Reset events, power state and lock control
  input wire logic hot_reset,
  input wire logic fund_reset,
  input wire logic aux_power,
  input wire logic register_unlock_bit,
  // Configuration accesses
  input wire rac_pkg::rac_req_type root_req,
  input wire rac_pkg::rac_req_type eeprom_req,
  output logic root_ack,
  output logic eeprom_ack,
  output logic [rac_pkg::RAC_WIDTH-1:0] rd_data,
  // Strap initialization
  input wire logic init_load,
  input wire logic [rac_pkg::RAC_WIDTH-1:0] init_value,
  // Hardware status side
  input wire logic [rac_pkg::RAC_WIDTH-1:0] hw_set,
  input wire logic [rac_pkg::RAC_WIDTH-1:0] hw_clr,
  output logic [rac_pkg::RAC_WIDTH-1:0] field_value
);
  import rac_pkg::*;

  // ************************************************************
  // Layout decoding
  // ************************************************************
  function automatic logic [RAC_WIDTH-1:0] attr_mask(
    input rac_layout_type layout,
    input rac_attr_type attr
  );
    logic [RAC_WIDTH-1:0] m;
    m = '0;
    for (int b = 0; b < RAC_WIDTH; b++)
    begin
      m[b] = (layout[b] == attr);
    end
    return m;
  endfunction : attr_mask

  localparam logic [RAC_WIDTH-1:0] TRANSIENT_MASK = attr_mask(BIT_ATTR, RAC_WRITE_TRANSIENT);
  localparam logic [RAC_WIDTH-1:0] READ_ZERO = TRANSIENT_MASK
    | attr_mask(BIT_ATTR, RAC_ZERO) | attr_mask(BIT_ATTR, RAC_RSVD);

  // Without a transient field every write is qualified
  function automatic logic write_qualified(input logic [RAC_WIDTH-1:0] data);
    return (TRANSIENT_MASK == '0) || ((data & TRANSIENT_MASK) != '0);
  endfunction : write_qualified

  // ************************************************************
  // Access selection
  // ************************************************************
  logic take_eeprom;
  logic take_root;
  rac_req_type acc;
  logic rd_take;
  logic wr_any;
  logic wr_fields;
  rac_ctl_type ctl;

  // Loader wins a collision; root holds its request until acknowledged
  assign take_eeprom = eeprom_req.valid; // R17
  assign take_root = root_req.valid && !eeprom_req.valid;
  assign acc = take_eeprom ? eeprom_req : root_req;
  assign rd_take = acc.valid && !acc.write;
  assign wr_any = acc.valid && acc.write;
  assign wr_fields = wr_any && write_qualified(acc.data); // R15 R17

  always_comb
  begin
    ctl.hot_reset = hot_reset;
    ctl.fund_reset = fund_reset;
    ctl.aux_power = aux_power;
    ctl.unlock = register_unlock_bit;
    ctl.write = wr_fields;
    ctl.read = rd_take;
    ctl.init_load = init_load;
  end

  // ************************************************************
  // Cells
  // ************************************************************
  for (genvar i = 0; i < RAC_WIDTH; i++)
  begin : g_cell
    rac_bit_cell #(
      .ATTR(BIT_ATTR[i]),
      .DEFAULT(DEFAULT_VALUE[i]),
      .FR_STICKY(FR_STICKY_MASK[i])
    ) u_cell (
      .clock(clock),
      .rst_n(rst_n),
      .ctl(ctl),
      .wr_bit(acc.data[i]),
      .init_bit(init_value[i]),
      .hw_set(hw_set[i]),
      .hw_clr(hw_clr[i]),
      .value(field_value[i])
    );
  end

  // ************************************************************
  // Answers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      root_ack <= 1'b0;
      eeprom_ack <= 1'b0;
    end
    else
    begin
      root_ack <= take_root;
      eeprom_ack <= take_eeprom;
    end
  end

  // Captured before read-clear takes effect on the same edge
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) rd_data <= '0;
    else if (rd_take) rd_data <= field_value & ~READ_ZERO; // R2 R15 R16
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic quiet;
  assign quiet = !hot_reset && !fund_reset;

  a_read_zero_bits : // R16
  assert property (@(posedge clock) disable iff (!rst_n)
    (rd_data & READ_ZERO) == '0)
  else $error("Zero or transient bit read back as one");

  a_read_capture : // R17
  assert property (@(posedge clock) disable iff (!rst_n)
    rd_take |=> rd_data == $past(field_value & ~READ_ZERO))
  else $error("Read data does not match bits at read time");

  a_loader_priority : // R17
  assert property (@(posedge clock) disable iff (!rst_n)
    eeprom_req.valid |=> eeprom_ack && !root_ack)
  else $error("Loader access not taken first");

  a_root_ack_taken : // R17
  assert property (@(posedge clock) disable iff (!rst_n)
    take_root |=> root_ack && !eeprom_ack)
  else $error("Root access taken without acknowledge");

  a_root_ack_idle : // R17
  assert property (@(posedge clock) disable iff (!rst_n)
    !take_root |=> !root_ack)
  else $error("Root acknowledge without a taken access");

  a_loader_ack_idle : // R17
  assert property (@(posedge clock) disable iff (!rst_n)
    !eeprom_req.valid |=> !eeprom_ack)
  else $error("Loader acknowledge without a request");

  a_read_data_hold : // R2
  assert property (@(posedge clock) disable iff (!rst_n)
    !rd_take |=> $stable(rd_data))
  else $error("Read data changed without a read");

  for (genvar i = 0; i < RAC_WIDTH; i++)
  begin : g_check
    if (BIT_ATTR[i] == RAC_HARDWARE_INITIALIZED)
    begin : g_strap
      a_strap_frozen : // R1
      assert property (@(posedge clock) disable iff (!rst_n)
        quiet && !init_load |=> $stable(field_value[i]))
      else $error("Strap bit changed without init or reset");
      a_strap_reload : // R1
      assert property (@(posedge clock) disable iff (!rst_n)
        (hot_reset || fund_reset) ##1 (quiet && init_load)
        |=> field_value[i] == $past(init_value[i]))
      else $error("Strap bit missed first load after reset");
    end
    if (BIT_ATTR[i] == RAC_RC || BIT_ATTR[i] == RAC_READ_CLEAR_WRITABLE)
    begin : g_rc
      a_rc_read_clear : // R2
      assert property (@(posedge clock) disable iff (!rst_n)
        rd_take && quiet && !hw_set[i] |=> !field_value[i])
      else $error("Read did not clear bit");
    end
    if (BIT_ATTR[i] == RAC_RC)
    begin : g_rc_wr
      a_rc_write_ignored : // R2
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_any && quiet && !hw_set[i] |=> $stable(field_value[i]))
      else $error("Write changed read-clear bit");
    end
    if (BIT_ATTR[i] == RAC_READ_CLEAR_WRITABLE || BIT_ATTR[i] == RAC_RW
      || BIT_ATTR[i] == RAC_STICKY_READ_WRITE)
    begin : g_store
      a_write_store : // R3
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_fields && quiet && !hw_set[i] |=> field_value[i] == $past(acc.data[i]))
      else $error("Written value not stored");
      a_transient_gate : // R15
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_any && !wr_fields && !rd_take && quiet && !hw_set[i]
        |=> $stable(field_value[i]))
      else $error("Unqualified write took effect");
      a_loader_store : // R17
      assert property (@(posedge clock) disable iff (!rst_n)
        take_eeprom && wr_fields && quiet && !hw_set[i]
        |=> field_value[i] == $past(eeprom_req.data[i]))
      else $error("Loader write not stored like a root write");
    end
    if (BIT_ATTR[i] == RAC_RO_CONST || BIT_ATTR[i] == RAC_RO_STATUS
      || BIT_ATTR[i] == RAC_STICKY_READ_ONLY)
    begin : g_ro
      a_ro_write_ignored : // R5
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_any && quiet && !hw_set[i] && !hw_clr[i] |=> $stable(field_value[i]))
      else $error("Write changed read-only bit");
    end
    if (BIT_ATTR[i] == RAC_RW1C || BIT_ATTR[i] == RAC_STICKY_WRITE_ONE_CLEAR)
    begin : g_w1c
      a_w1c_zero_keeps : // R7
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_any && !acc.data[i] && quiet && !hw_set[i] |=> $stable(field_value[i]))
      else $error("Writing zero changed one-clear bit");
      a_w1c_one_clears : // R7
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_fields && acc.data[i] && !hw_set[i] && quiet |=> !field_value[i])
      else $error("Writing one did not clear bit");
      a_w1c_hw_only : // R8
      assert property (@(posedge clock) disable iff (!rst_n)
        $rose(field_value[i]) |-> $past(hw_set[i]))
      else $error("One-clear bit set without hardware event");
      a_w1c_no_hw_clear : // R8
      assert property (@(posedge clock) disable iff (!rst_n)
        $fell(field_value[i]) |-> $past(wr_fields && acc.data[i])
          || $past(hot_reset || fund_reset))
      else $error("One-clear bit cleared without write of one");
      a_set_wins : // R18
      assert property (@(posedge clock) disable iff (!rst_n)
        hw_set[i] && wr_fields && acc.data[i] && quiet |=> field_value[i])
      else $error("Set event lost to same-cycle clear");
      a_w1c_clr_ignored : // R8
      assert property (@(posedge clock) disable iff (!rst_n)
        hw_clr[i] && !wr_fields && quiet |=> !$fell(field_value[i]))
      else $error("Hardware clear reached a one-clear bit");
    end
    if (BIT_ATTR[i] == RAC_WRITE_WHEN_UNLOCKED)
    begin : g_lock
      a_lock_refuses : // R9
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_any && !register_unlock_bit && quiet |=> $stable(field_value[i]))
      else $error("Locked bit accepted a write");
      a_lock_open_store : // R9
      assert property (@(posedge clock) disable iff (!rst_n)
        wr_fields && register_unlock_bit && quiet
        |=> field_value[i] == $past(acc.data[i]))
      else $error("Unlocked write not stored");
      a_lock_fund_default : // R10
      assert property (@(posedge clock) disable iff (!rst_n)
        fund_reset |=> field_value[i] == DEFAULT_VALUE[i])
      else $error("Locked bit kept value over fundamental reset");
    end
    if (BIT_ATTR[i] == RAC_RO_CONST)
    begin : g_const
      a_const_fixed : // R5
      assert property (@(posedge clock) disable iff (!rst_n)
        field_value[i] == DEFAULT_VALUE[i])
      else $error("Constant read-only bit changed");
    end
    if (BIT_ATTR[i] == RAC_RO_STATUS || BIT_ATTR[i] == RAC_STICKY_READ_ONLY)
    begin : g_status
      a_status_set : // R5
      assert property (@(posedge clock) disable iff (!rst_n)
        hw_set[i] && quiet |=> field_value[i])
      else $error("Status bit missed hardware set");
      a_status_clear : // R5
      assert property (@(posedge clock) disable iff (!rst_n)
        hw_clr[i] && !hw_set[i] && quiet |=> !field_value[i])
      else $error("Status bit missed hardware clear");
    end
    if (BIT_ATTR[i] == RAC_WRITE_TRANSIENT || BIT_ATTR[i] == RAC_ZERO
      || BIT_ATTR[i] == RAC_RSVD)
    begin : g_zero
      a_zero_cell_low : // R15 R16
      assert property (@(posedge clock) disable iff (!rst_n)
        !field_value[i])
      else $error("Zero or transient cell holds a one");
    end
    if (is_sticky(BIT_ATTR[i]))
    begin : g_sticky
      a_sticky_hot_keep : // R11 R13 R14
      assert property (@(posedge clock) disable iff (!rst_n)
        hot_reset && !fund_reset && !wr_any && !hw_set[i] && !hw_clr[i]
        |=> $stable(field_value[i]))
      else $error("Sticky bit altered by hot reset");
    end
    else
    begin : g_plain
      a_plain_hot_default : // R10
      assert property (@(posedge clock) disable iff (!rst_n)
        hot_reset || fund_reset |=> field_value[i] == DEFAULT_VALUE[i])
      else $error("Non-sticky bit missed reset default");
    end
    if (is_fr_capable(BIT_ATTR[i]))
    begin : g_fr
      a_fr_aux_keep : // R12
      assert property (@(posedge clock) disable iff (!rst_n)
        fund_reset && aux_power && FR_STICKY_MASK[i] && !wr_any
        && !hw_set[i] && !hw_clr[i] |=> $stable(field_value[i]))
      else $error("Marked sticky bit lost on aux power");
      a_fr_main_default : // R12
      assert property (@(posedge clock) disable iff (!rst_n)
        fund_reset && !(aux_power && FR_STICKY_MASK[i])
        |=> field_value[i] == DEFAULT_VALUE[i])
      else $error("Sticky bit kept value without aux power");
    end
  end

endmodule : rac_bank

// ==== rtl/rac_bit_cell.sv ====
`timescale 1ns/1ps
// ************************************************************
// One attribute cell
// ************************************************************
module rac_bit_cell #(
  parameter rac_pkg::rac_attr_type ATTR = rac_pkg::RAC_RW,
  parameter logic DEFAULT = 1'b0,
  parameter logic FR_STICKY = 1'b0
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // Shared access and reset control
  input wire rac_pkg::rac_ctl_type ctl,
  // Per-bit data
  input wire logic wr_bit,
  input wire logic init_bit,
  input wire logic hw_set,
  input wire logic hw_clr,
  // Stored bit
  output logic value
);
  import rac_pkg::*;

  logic loaded;
  logic reset_now;
  logic next_value;

  // Sticky cells keep running through a hot reset pulse, and marked ones through a fundamental reset on aux power, so no event is lost
  always_comb
  begin
    reset_now = 1'b0;
    if (ctl.fund_reset)
    begin
      reset_now = !(is_fr_capable(ATTR) && FR_STICKY && ctl.aux_power); // R10 R12
    end
    else if (ctl.hot_reset)
    begin
      reset_now = !is_sticky(ATTR); // R10 R11 R13 R14
    end
  end

  always_comb
  begin
    next_value = value;
    if (reset_now)
    begin
      next_value = DEFAULT;
    end
    else
    begin
      unique case (ATTR)
        RAC_HARDWARE_INITIALIZED:
          if (ctl.init_load && !loaded) next_value = init_bit; // R1
        RAC_RO_CONST:
          next_value = DEFAULT; // R5
        RAC_RO_STATUS, RAC_STICKY_READ_ONLY:
          if (hw_set) next_value = 1'b1; // R5 R11
          else if (hw_clr) next_value = 1'b0;
        RAC_RC:
          if (hw_set) next_value = 1'b1; // R2
          else if (ctl.read) next_value = 1'b0;
        RAC_READ_CLEAR_WRITABLE:
          if (hw_set) next_value = 1'b1; // R3
          else if (ctl.write) next_value = wr_bit;
          else if (ctl.read) next_value = 1'b0;
        RAC_RW, RAC_STICKY_READ_WRITE:
          if (ctl.write) next_value = wr_bit; // R6 R13
        RAC_RW1C, RAC_STICKY_WRITE_ONE_CLEAR:
          if (hw_set) next_value = 1'b1; // R7 R8 R14 R18
          else if (ctl.write && wr_bit) next_value = 1'b0;
        RAC_WRITE_WHEN_UNLOCKED:
          if (ctl.write && ctl.unlock) next_value = wr_bit; // R9
        RAC_WRITE_TRANSIENT, RAC_ZERO, RAC_RSVD:
          next_value = 1'b0; // R15 R16
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) value <= DEFAULT;
    else value <= next_value;
  end

  // Reopened by any reset that returns the bit to default
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n) loaded <= 1'b0;
    else if (reset_now) loaded <= 1'b0;
    else if (ctl.init_load) loaded <= 1'b1; // R1
  end

endmodule : rac_bit_cell

// ==== rtl/rac_pkg.sv ====
// ************************************************************
// Attribute encodings and bank layout
// ************************************************************
package rac_pkg;

  localparam int RAC_WIDTH = 16;

  typedef enum logic [13:0] {
    RAC_HARDWARE_INITIALIZED = 14'h0001,
    RAC_RO_CONST = 14'h0002,
    RAC_RO_STATUS = 14'h0004,
    RAC_RC = 14'h0008,
    RAC_READ_CLEAR_WRITABLE = 14'h0010,
    RAC_RW = 14'h0020,
    RAC_RW1C = 14'h0040,
    RAC_WRITE_WHEN_UNLOCKED = 14'h0080,
    RAC_STICKY_READ_ONLY = 14'h0100,
    RAC_STICKY_READ_WRITE = 14'h0200,
    RAC_STICKY_WRITE_ONE_CLEAR = 14'h0400,
    RAC_WRITE_TRANSIENT = 14'h0800,
    RAC_ZERO = 14'h1000,
    RAC_RSVD = 14'h2000
  } rac_attr_type;

  typedef rac_attr_type rac_layout_type [RAC_WIDTH];

  // Bit 0 upward
  localparam rac_layout_type RAC_DEFAULT_LAYOUT = '{
    RAC_HARDWARE_INITIALIZED, RAC_RO_CONST, RAC_RO_STATUS, RAC_RC,
    RAC_READ_CLEAR_WRITABLE, RAC_RW, RAC_RW1C, RAC_WRITE_WHEN_UNLOCKED,
    RAC_STICKY_READ_ONLY, RAC_STICKY_READ_WRITE, RAC_STICKY_WRITE_ONE_CLEAR,
    RAC_WRITE_TRANSIENT, RAC_ZERO, RAC_RSVD, RAC_STICKY_WRITE_ONE_CLEAR,
    RAC_STICKY_READ_WRITE
  };
  localparam logic [RAC_WIDTH-1:0] RAC_DEFAULT_VALUE = 16'h0002;
  localparam logic [RAC_WIDTH-1:0] RAC_DEFAULT_FR_STICKY = 16'hc000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [RAC_WIDTH-1:0] data;
  } rac_req_type;

  typedef struct packed {
    logic hot_reset;
    logic fund_reset;
    logic aux_power;
    logic unlock;
    logic write;
    logic read;
    logic init_load;
  } rac_ctl_type;

  // Kept through hot reset
  function automatic logic is_sticky(input rac_attr_type attr);
    return (attr == RAC_WRITE_WHEN_UNLOCKED) || (attr == RAC_STICKY_READ_ONLY)
      || (attr == RAC_STICKY_READ_WRITE) || (attr == RAC_STICKY_WRITE_ONE_CLEAR);
  endfunction : is_sticky

  // May also survive fundamental reset on aux power
  function automatic logic is_fr_capable(input rac_attr_type attr);
    return (attr == RAC_STICKY_READ_ONLY) || (attr == RAC_STICKY_READ_WRITE)
      || (attr == RAC_STICKY_WRITE_ONE_CLEAR);
  endfunction : is_fr_capable

endpackage : rac_pkg

// ==== sim/rac_access_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// Root and loader access model
// ************************************************************
module rac_access_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Access requests
  output rac_pkg::rac_req_type root_req,
  output rac_pkg::rac_req_type eeprom_req
);
  import rac_pkg::*;
  integer seed = 32'h4af8;
  task automatic make_req(input rac_req_type prev, output rac_req_type r);
    r.valid = (($random(seed) & 3) == 0);
    r.write = 1'($random(seed));
    r.data = 16'($random(seed));
    if (($random(seed) & 3) != 0)
      r.data[11] = 1'b1;
    // Reserved read back as zero, so the merge writes zero
    r.data[13] = 1'b0;
    r.data[12] = 1'b0;
    // Released lines show no stale value
    if (!r.valid)
      r.data = ~prev.data;
  endtask : make_req
  always @(negedge clock)
  begin : drive
    rac_req_type r;
    if (!rst_n)
    begin
      root_req <= '0;
      eeprom_req <= '0;
    end
    else
    begin
      // Refused root request is held unchanged
      if (!(root_req.valid && eeprom_req.valid))
      begin
        make_req(root_req, r);
        root_req <= r;
      end
      make_req(eeprom_req, r);
      eeprom_req <= r;
    end
  end
endmodule : rac_access_model

// ==== sim/rac_bank_test.sv ====
`timescale 1ns/1ps
// ************************************************************
// Attribute bank testbench
// ************************************************************
module rac_bank_test;
  import rac_pkg::*;
  localparam int LIMIT = 5000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hot_reset = 1'b0;
  logic fund_reset = 1'b0;
  logic aux_power = 1'b0;
  logic register_unlock_bit = 1'b0;
  logic init_load = 1'b0;
  logic [15:0] init_value = '0;
  logic [15:0] hw_set = '0;
  logic [15:0] hw_clr = '0;
  rac_req_type root_req;
  rac_req_type eeprom_req;
  rac_req_type req;
  logic root_ack;
  logic eeprom_ack;
  logic [15:0] rd_data;
  logic [15:0] field_value;
  logic [15:0] exp_val;
  logic [15:0] exp_rd;
  logic [15:0] nv;
  logic exp_ra;
  logic exp_ea;
  logic loaded;
  logic rd;
  logic wr;
  integer seed = 32'h4af8;
  integer errors = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer i;
  integer b;
  initial
  begin
    forever
      #5 clock = ~clock;
  end
  rac_access_model partner_u (.clock(clock), .rst_n(rst_n), .root_req(root_req),
    .eeprom_req(eeprom_req));
  rac_bank dut_u (.clock(clock), .rst_n(rst_n), .hot_reset(hot_reset),
    .fund_reset(fund_reset), .aux_power(aux_power),
    .register_unlock_bit(register_unlock_bit), .root_req(root_req),
    .eeprom_req(eeprom_req), .root_ack(root_ack), .eeprom_ack(eeprom_ack),
    .rd_data(rd_data), .init_load(init_load), .init_value(init_value),
    .hw_set(hw_set), .hw_clr(hw_clr), .field_value(field_value));
  // ************************************************************
  // Expected behaviour
  // ************************************************************
  function automatic logic transient_open(input logic [15:0] d);
    logic any;
    logic hit;
    any = 1'b0;
    hit = 1'b0;
    for (int j = 0; j < RAC_WIDTH; j++)
    begin
      if (RAC_DEFAULT_LAYOUT[j] == RAC_WRITE_TRANSIENT)
      begin
        any = 1'b1;
        hit = hit | d[j];
      end
    end
    return !any || hit;
  endfunction : transient_open
  function automatic logic next_bit(input rac_attr_type a, input logic c, input logic s,
    input logic k, input logic d, input logic iv, input logic dflt, input logic frm);
    logic n;
    logic stk;
    logic frk;
    n = c;
    case (a)
      RAC_HARDWARE_INITIALIZED: if (init_load && !loaded) n = iv;
      RAC_RO_STATUS, RAC_STICKY_READ_ONLY: n = s ? 1'b1 : (k ? 1'b0 : c);
      RAC_RC: n = s ? 1'b1 : (rd ? 1'b0 : c);
      RAC_READ_CLEAR_WRITABLE: n = s ? 1'b1 : (rd ? 1'b0 : (wr ? d : c));
      RAC_RW, RAC_STICKY_READ_WRITE: n = wr ? d : c;
      RAC_RW1C, RAC_STICKY_WRITE_ONE_CLEAR: n = s ? 1'b1 : ((wr && d) ? 1'b0 : c);
      RAC_WRITE_WHEN_UNLOCKED: n = (wr && register_unlock_bit) ? d : c;
      default: n = c;
    endcase
    stk = (a == RAC_WRITE_WHEN_UNLOCKED) || (a == RAC_STICKY_READ_ONLY)
      || (a == RAC_STICKY_READ_WRITE) || (a == RAC_STICKY_WRITE_ONE_CLEAR);
    frk = stk && (a != RAC_WRITE_WHEN_UNLOCKED) && frm && aux_power;
    if ((fund_reset && !frk) || (hot_reset && !stk))
      n = dflt;
    return n;
  endfunction : next_bit
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exp_val <= RAC_DEFAULT_VALUE;
      exp_rd <= '0;
      exp_ra <= 1'b0;
      exp_ea <= 1'b0;
      loaded <= 1'b0;
    end
    else
    begin
      req = eeprom_req.valid ? eeprom_req : root_req;
      rd = req.valid && !req.write;
      wr = req.valid && req.write && transient_open(req.data);
      for (b = 0; b < RAC_WIDTH; b++)
        nv[b] = next_bit(RAC_DEFAULT_LAYOUT[b], exp_val[b], hw_set[b], hw_clr[b],
          req.data[b], init_value[b], RAC_DEFAULT_VALUE[b], RAC_DEFAULT_FR_STICKY[b]);
      exp_val <= nv;
      if (rd)
        exp_rd <= exp_val;
      exp_ra <= root_req.valid && !eeprom_req.valid;
      exp_ea <= eeprom_req.valid;
      loaded <= (hot_reset || fund_reset) ? 1'b0 : (loaded || init_load);
    end
  end
  // ************************************************************
  // Checking and closing
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    total_checks = total_checks + 1;
    if (seen !== expected)
    begin
      errors = errors + 1;
      $display("mismatch at %0t seen %h expected %h", $time, seen, expected);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles >= LIMIT)
    begin
      errors = errors + 1;
      end_sim();
    end
  end
  initial
  begin
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      @(negedge clock);
      check(field_value & 16'h0001, exp_val & 16'h0001);
      check(field_value & 16'h0006, exp_val & 16'h0006);
      check(field_value & 16'h0008, exp_val & 16'h0008);
      check(field_value & 16'h0030, exp_val & 16'h0030);
      check(field_value & 16'h0040, exp_val & 16'h0040);
      check(field_value & 16'h0080, exp_val & 16'h0080);
      check(field_value & 16'h0100, exp_val & 16'h0100);
      check(field_value & 16'h8200, exp_val & 16'h8200);
      check(field_value & 16'h4400, exp_val & 16'h4400);
      check(field_value & 16'h3800, exp_val & 16'h3800);
      check(rd_data, exp_rd);
      check({14'h0, root_ack, eeprom_ack}, {14'h0, exp_ra, exp_ea});
      hot_reset = (($random(seed) & 63) == 0) || (i == 1500);
      fund_reset = (($random(seed) & 63) == 0) || (i == 500) || (i == 1000);
      if (($random(seed) & 31) == 0)
        aux_power = ~aux_power;
      if (i == 500)
        aux_power = 1'b1;
      if (i == 1000)
        aux_power = 1'b0;
      register_unlock_bit = (i < 2000) ? 1'($random(seed)) : 1'b0;
      init_load = (($random(seed) & 15) == 0);
      init_value = 16'($random(seed));
      // Sets reach only cells that take them; clears also reach the one-clear cells
      hw_set = 16'($random(seed) & $random(seed)) & 16'h455c;
      if (i % 97 == 0)
        hw_set = 16'h455c;
      hw_clr = 16'($random(seed)) & 16'h4544;
      rst_n = (i != 2500);
    end
    end_sim();
  end
endmodule : rac_bank_test
